// file: dual_channel_deadtime_mode_logic.sv
// Two-channel gate command logic with half-bridge dead time and direct mode.
// Assumes inputs synchronous to ref_clk and a jumper that is static in use.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Static jumper picks mode: position 1 direct, position 3 half-bridge.
// - Half-bridge: first input switches, second input enables both channels.
// - Half-bridge with enable dark: both channels held off.
// - Half-bridge with enable lit: channels follow the switching command.
// - Command rising: channel one off now, channel two on after dead time.
// - Dead time comes from a configurable count, not a fixed constant.
// - Direct: no interlock, each input drives its own channel.
// - Direct: lit input always turns its channel on.
// - Direct: both channels may overlap; nothing suppressed, only the one-cycle output register delay.
module dual_channel_deadtime_mode_logic #(
    parameter int WIDTH = deadtime_mode_pkg::DEADTIME_WIDTH,
    parameter logic [WIDTH-1:0] DEAD_CYCLES = WIDTH'(deadtime_mode_pkg::DEADTIME_CYCLES)
) (
    // Clock and reset
    input  wire logic                            ref_clk,
    input  wire logic                            resetn,
    // Mode jumper
    input  wire logic [1:0]                      mode_select_jumper,
    // Optical command inputs
    input  wire deadtime_mode_pkg::optical_in_t  opticalIn,
    // Gate-drive commands
    output var  deadtime_mode_pkg::channel_out_t channelOut,
    output var  logic                            halfBridgeActive
);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF      = 3'b001,
        ST_WAIT     = 3'b010,
        ST_ON       = 3'b100
    } phase_t;

    logic   halfBridge;
    logic   enableLit;
    logic   command;
    logic   cmdPrev_q;
    logic   cmdEdge;
    logic   expired;
    logic   reloadTimer;
    phase_t phase_q;
    phase_t phase_d;
    deadtime_mode_pkg::channel_out_t hbOut;
    deadtime_mode_pkg::channel_out_t directOut;
    deadtime_mode_pkg::channel_out_t nextOut;

    // Jumper at position 3 selects half-bridge; anything else acts as direct.
    assign halfBridge = (mode_select_jumper == deadtime_mode_pkg::JUMPER_HALFBRIDGE);
    assign enableLit  = opticalIn.secondOptical;
    assign command    = opticalIn.switchCommand;
    assign cmdEdge    = (command != cmdPrev_q);
    // The timer also reloads while idle, so enable rising waits a full dead time too.
    assign reloadTimer = cmdEdge || !enableLit || (phase_q == ST_OFF);

    // ------------------------------------------------------------
    // Dead-time timer
    // ------------------------------------------------------------
    deadtime_counter #(
        .WIDTH     (WIDTH)
    ) u_deadtime (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .load      (reloadTimer),
        .loadValue (DEAD_CYCLES),
        .expired   (expired)
    );

    // ------------------------------------------------------------
    // Half-bridge phase sequencing
    // ------------------------------------------------------------
    // An edge of the command kills the conducting channel and waits out the dead time.
    always_comb
    begin
        phase_d = phase_q;
        case (phase_q)
            ST_OFF:  phase_d = enableLit ? ST_WAIT : ST_OFF;
            ST_WAIT: phase_d = !enableLit ? ST_OFF : (expired ? ST_ON : ST_WAIT);
            ST_ON:   phase_d = !enableLit ? ST_OFF : (cmdEdge ? ST_WAIT : ST_ON);
            default: phase_d = ST_OFF;
        endcase
    end

    // Channel two follows a high command, channel one a low one, only in ST_ON.
    assign hbOut.channelTwo = (phase_d == ST_ON) && command;
    assign hbOut.channelOne = (phase_d == ST_ON) && !command;
    // Direct mode passes each input straight through to its channel.
    assign directOut.channelOne = opticalIn.switchCommand;
    assign directOut.channelTwo = opticalIn.secondOptical;
    assign nextOut = halfBridge ? hbOut : directOut;

    // Phase, edge history and output registers.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phase_q          <= ST_OFF;
            cmdPrev_q        <= 1'b0;
            channelOut       <= '{deadtime_mode_pkg::RESET_CHANNEL, deadtime_mode_pkg::RESET_CHANNEL};
            halfBridgeActive <= 1'b0;
        end
        else
        begin
            phase_q          <= phase_d;
            cmdPrev_q        <= command;
            channelOut       <= nextOut;
            halfBridgeActive <= halfBridge;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hb_disabled_off;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridge && !enableLit) |=> (channelOut == '0);
    endproperty
    a_hb_disabled_off: assert property (p_hb_disabled_off) else $error("Half-bridge disabled but a channel is on.");

    property p_hb_never_both;
        @(posedge ref_clk) disable iff (!resetn)
        halfBridgeActive && $past(halfBridge) |-> !(channelOut.channelOne && channelOut.channelTwo);
    endproperty
    a_hb_never_both: assert property (p_hb_never_both) else $error("Both channels on in half-bridge mode.");

    property p_rise_one_off;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridge && enableLit && command && !cmdPrev_q) |=> !channelOut.channelOne;
    endproperty
    a_rise_one_off: assert property (p_rise_one_off) else $error("Channel one not off after command rise.");

    property p_rise_two_waits;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridge && enableLit && command && !cmdPrev_q) |=> !channelOut.channelTwo;
    endproperty
    a_rise_two_waits: assert property (p_rise_two_waits) else $error("Channel two on without dead time.");

    property p_fall_two_off;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridge && !command && cmdPrev_q) |=> !channelOut.channelTwo && !channelOut.channelOne;
    endproperty
    a_fall_two_off: assert property (p_fall_two_off) else $error("Channel two not off after command fall.");

    property p_direct_one;
        @(posedge ref_clk) disable iff (!resetn)
        !halfBridge |=> (channelOut.channelOne == $past(opticalIn.switchCommand));
    endproperty
    a_direct_one: assert property (p_direct_one) else $error("Direct channel one does not follow its input.");

    property p_direct_two;
        @(posedge ref_clk) disable iff (!resetn)
        !halfBridge |=> (channelOut.channelTwo == $past(opticalIn.secondOptical));
    endproperty
    a_direct_two: assert property (p_direct_two) else $error("Direct channel two does not follow its input.");

    property p_direct_overlap;
        @(posedge ref_clk) disable iff (!resetn)
        (!halfBridge && command && enableLit) |=> (channelOut == 2'h3);
    endproperty
    a_direct_overlap: assert property (p_direct_overlap) else $error("Direct overlap suppressed.");

    property p_mode_decode;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_select_jumper == deadtime_mode_pkg::JUMPER_DIRECT) |=> !halfBridgeActive;
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("Jumper position 1 did not select direct mode.");

    // ------------------------------------------------------------
    // Sequencing checks
    // ------------------------------------------------------------
    // Jumper position 3 must show up as half-bridge one cycle later.
    property p_mode_halfbridge;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_select_jumper == deadtime_mode_pkg::JUMPER_HALFBRIDGE) |=> halfBridgeActive;
    endproperty
    a_mode_halfbridge: assert property (p_mode_halfbridge) else $error("Position 3 missed half-bridge.");

    // Two dark inputs in direct mode turn both channels off.
    property p_direct_dark;
        @(posedge ref_clk) disable iff (!resetn)
        (!halfBridge && !command && !enableLit) |=> (channelOut == '0);
    endproperty
    a_direct_dark: assert property (p_direct_dark) else $error("Dark direct input left a channel on.");

    // Once conducting, exactly one channel is on and the command picks it.
    property p_hb_follow;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridge && enableLit && (phase_d == ST_ON)) |=>
            (channelOut.channelTwo == $past(command)) && (channelOut.channelOne != channelOut.channelTwo);
    endproperty
    a_hb_follow: assert property (p_hb_follow) else $error("Half-bridge does not follow the command.");

    // Enable coming on never lets a channel straight through.
    property p_enable_rise_wait;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridge && enableLit && !$past(enableLit)) |=> (channelOut == '0);
    endproperty
    a_enable_rise_wait: assert property (p_enable_rise_wait) else $error("Enable rise not held off.");

    // Any command edge while enabled restarts the dead time.
    property p_cmd_restart;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridge && enableLit && cmdEdge) |=> (phase_q == ST_WAIT);
    endproperty
    a_cmd_restart: assert property (p_cmd_restart) else $error("Command edge did not restart.");

    // Outside the conducting phase both channels stay off.
    property p_hold_off_waiting;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridge && (phase_d != ST_ON)) |=> (channelOut == '0);
    endproperty
    a_hold_off_waiting: assert property (p_hold_off_waiting) else $error("Channel on while waiting.");

    // Channel two may only come on once the timer has run out.
    property p_two_after_dead;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridgeActive && $rose(channelOut.channelTwo)) |-> $past(expired);
    endproperty
    a_two_after_dead: assert property (p_two_after_dead) else $error("Channel two on before dead time.");

    // Channel one may only come on once the timer has run out.
    property p_one_after_dead;
        @(posedge ref_clk) disable iff (!resetn)
        (halfBridgeActive && $rose(channelOut.channelOne)) |-> $past(expired);
    endproperty
    a_one_after_dead: assert property (p_one_after_dead) else $error("Channel one on before dead time.");

    // The phase register keeps exactly one state bit set.
    property p_phase_onehot;
        @(posedge ref_clk) disable iff (!resetn)
        $onehot(phase_q);
    endproperty
    a_phase_onehot: assert property (p_phase_onehot) else $error("Phase register lost its one-hot code.");

endmodule

`default_nettype wire

// file: deadtime_mode_pkg.sv
// Shared constants and types for the dual-channel dead-time mode logic.
// Assumes a single 40 MHz clock domain in the user of this package.
`default_nettype none

package deadtime_mode_pkg;

    // ------------------------------------------------------------
    // Mode-select jumper positions
    // ------------------------------------------------------------
    localparam logic [1:0] JUMPER_DIRECT     = 2'h1;
    localparam logic [1:0] JUMPER_HALFBRIDGE = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 25000;
    localparam int DEADTIME_NS       = 1000;
    localparam int DEADTIME_CYCLES   = (DEADTIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DEADTIME_WIDTH    = 12;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RESET_CHANNEL   = 1'b0;

    // Optical command pair as seen at the inputs.
    typedef struct packed {
        logic switchCommand;
        logic secondOptical;
    } optical_in_t;

    // Gate-drive command pair.
    typedef struct packed {
        logic channelOne;
        logic channelTwo;
    } channel_out_t;

endpackage

`default_nettype wire

// file: deadtime_counter.sv
// Dead-time down-counter that reports when a load has elapsed.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module deadtime_counter #(
    parameter int WIDTH = deadtime_mode_pkg::DEADTIME_WIDTH
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    // Status
    output var  logic             expired
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // Reload on request, otherwise count down to zero and stay.
    assign count_d = load ? loadValue : ((count_q != '0) ? count_q - 1'b1 : count_q);
    assign expired = (count_q == '0) && !load;

    // Counter register.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_d;
        end
    end

endmodule

`default_nettype wire

// file: host_optics.sv
// Host control electronics model that drives both optical command inputs.
// Assumes ref_clk from the bench; drives just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module host_optics (
    // Clock
    input  wire logic                           ref_clk,
    // Optical commands
    output var  deadtime_mode_pkg::optical_in_t opticalIn
);
    // Both lines start dark, which is the off level.
    initial opticalIn = '0;

    // Drives the switching command and the second input together just after the next rising edge.
    task automatic send(input logic sw, input logic en);
        @(posedge ref_clk);
        #1;
        opticalIn = {sw, en};
    endtask
endmodule

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the dual-channel dead-time mode logic.
// Assumes the host model drives the optical inputs; dead time set short.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int DEAD = 3;
    logic                            ref_clk = 1'b0;
    logic                            resetn = 1'b0;
    logic [1:0]                      jumper = deadtime_mode_pkg::JUMPER_DIRECT;
    deadtime_mode_pkg::optical_in_t  opticalIn;
    deadtime_mode_pkg::channel_out_t channelOut;
    logic                            halfBridgeActive;
    int                              numErrors = 0;
    int                              numChecks = 0;
    int                              lat;

    // -------------------------------------------------------------
    // Clock, partner and design
    // -------------------------------------------------------------
    always #12.5 ref_clk = ~ref_clk;

    host_optics host_u (.ref_clk(ref_clk), .opticalIn(opticalIn));

    dual_channel_deadtime_mode_logic #(.WIDTH(12), .DEAD_CYCLES(12'(DEAD))) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .mode_select_jumper(jumper),
        .opticalIn(opticalIn), .channelOut(channelOut), .halfBridgeActive(halfBridgeActive));

    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic conclude();
        $display("Checks %0d, errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits a bounded number of edges for the outputs and returns the count.
    task automatic waitOut(input logic [1:0] exp, output int n);
        n = 0;
        while (channelOut !== exp && n < 50)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(12'(channelOut), 12'(exp));
        if (n >= 50) conclude();
    endtask

    // Both off from the edge that takes the change until the timer runs out, then one channel on.
    task automatic deadSeq(input logic sw, input logic en, input logic [1:0] expOn);
        host_u.send(sw, en);
        repeat (DEAD + 1)
        begin
            @(posedge ref_clk);
            #1;
            check(12'(channelOut), 12'h000);
        end
        @(posedge ref_clk);
        #1;
        check(12'(channelOut), 12'(expOn));
    endtask

    task automatic doReset(input logic [1:0] j);
        resetn = 1'b0;
        jumper = j;
        repeat (6) @(posedge ref_clk);
        #1;
        check(12'(channelOut), 12'h000);
        resetn = 1'b1;
        // One edge after release lets the registered mode flag settle.
        @(posedge ref_clk);
        #1;
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    // Each channel follows its own input one cycle later, overlap allowed.
    task automatic test_direct();
        logic [1:0] pat [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
        doReset(deadtime_mode_pkg::JUMPER_DIRECT);
        check(12'(halfBridgeActive), 12'h000);
        foreach (pat[i])
        begin
            host_u.send(pat[i][1], pat[i][0]);
            waitOut(pat[i], lat);
            check(12'(lat), 12'h001);
        end
    endtask

    // Enable gating, dead time on both edges and restart within the dead time.
    task automatic test_halfbridge();
        doReset(deadtime_mode_pkg::JUMPER_HALFBRIDGE);
        check(12'(halfBridgeActive), 12'h001);
        host_u.send(1'b1, 1'b0);
        repeat (DEAD + 3) @(posedge ref_clk);
        #1;
        check(12'(channelOut), 12'h000);
        deadSeq(1'b0, 1'b1, 2'h2);
        deadSeq(1'b1, 1'b1, 2'h1);
        deadSeq(1'b0, 1'b1, 2'h2);
        host_u.send(1'b1, 1'b1);
        deadSeq(1'b0, 1'b1, 2'h2);
        host_u.send(1'b0, 1'b0);
        waitOut(2'h0, lat);
        check(12'(lat), 12'h001);
        deadSeq(1'b0, 1'b1, 2'h2);
    endtask

    initial
    begin
        test_direct();
        test_halfbridge();
        conclude();
    end
endmodule

`default_nettype wire
